// ### rtl/core_status_defs.vh
`ifndef CORE_STATUS_DEFS_VH
`define CORE_STATUS_DEFS_VH
// Register location in the low seven address bits (mirrored in every bank)
`define CS_OFFSET 7'h03
// Field positions
`define CS_IRP_BIT 7
`define CS_RPHI_BIT 6
`define CS_RPLO_BIT 5
`define CS_WDX_BIT 4
`define CS_SLP_BIT 3
`define CS_Z_BIT 2
`define CS_DC_BIT 1
`define CS_C_BIT 0
// Reset value: bank bits 0, reset-cause bits 1, flags 0
`define CS_RESET 8'h18
// Flag-update mask (zero, nibble wrap, carry)
`define CS_FLAG_MASK 8'h07
// Reset-cause mask
`define CS_CAUSE_MASK 8'h18
// Operation classes from the core decoder
`define OP_NONE 3'h0
`define OP_ALU 3'h1
`define OP_SUB 3'h2
`define OP_ROR 3'h3
`define OP_ROL 3'h4
`define OP_CLR 3'h5
`endif

// ### rtl/cpu_status_register.v
`timescale 1ns/1ns
`default_nettype none
`include "core_status_defs.vh"

module cpu_status_register #(
  parameter ADDR_W = 9
) (
  input wire clk,
  input wire sys_rst,
  input wire [6:0] fileAddr,
  input wire writeEn,
  input wire [7:0] writeData,
  input wire [2:0] opClass,
  input wire flagsUpdate,
  input wire zeroIn,
  input wire carryIn,
  input wire nibbleCarryIn,
  input wire [7:0] rotSrc,
  input wire watchdogKick,
  input wire sleepOp,
  input wire watchdogTimeout,
  input wire [6:0] directAddr,
  input wire [7:0] indirectPtr,
  output reg [7:0] statusOut,
  output reg [ADDR_W-1:0] directFullAddr,
  output reg [ADDR_W-1:0] indirectFullAddr
);

  // Stored status and its next value
  reg [7:0] status_q;
  reg [7:0] status_d;

  // Decoded strobes for this cycle
  reg hitStatus;
  reg clearHit;
  reg flagZero;
  reg flagNibble;
  reg flagCarry;

  // Flag sources after operation-specific shaping
  reg carryNew;
  reg nibbleNew;

  // Write value before flag and cause overrides
  reg [7:0] writeMerged;

  // Reset-cause bits after hardware events
  reg expiryNext;
  reg sleepNext;

  // Bank bits feeding the address outputs
  reg [1:0] directBankNext;
  reg indirectBankNext;

  // Destination is status in any bank (low seven bits only)
  function isStatusHit;
    input en;
    input [6:0] addr;
    begin
      isStatusHit = en && (addr == `CS_OFFSET);
    end
  endfunction

  // Operation classes that write the nibble wrap bit
  function updatesNibble;
    input [2:0] op;
    begin
      updatesNibble = (op == `OP_ALU) || (op == `OP_SUB);
    end
  endfunction

  // Operation classes that write the carry bit
  function updatesCarry;
    input [2:0] op;
    begin
      updatesCarry = (op == `OP_ALU) || (op == `OP_SUB) || (op == `OP_ROR) || (op == `OP_ROL);
    end
  endfunction

  // Write data merged with protected bits kept from old value
  function [7:0] mergeKeep;
    input [7:0] data;
    input [7:0] old;
    input [7:0] keep;
    begin
      mergeKeep = (data & ~keep) | (old & keep);
    end
  endfunction

  // Strobe decode; a clear on status wins over flag update
  always @*
  begin
    hitStatus = isStatusHit(writeEn, fileAddr);
    clearHit = hitStatus && (opClass == `OP_CLR);
    flagZero = flagsUpdate && !clearHit;
    flagNibble = flagZero && updatesNibble(opClass);
    flagCarry = flagZero && updatesCarry(opClass);
  end

  // Carry and nibble wrap source per operation class
  always @*
  begin
    carryNew = carryIn;
    nibbleNew = nibbleCarryIn;
    case (opClass)
      `OP_SUB:
      begin
        carryNew = ~carryIn;
        nibbleNew = ~nibbleCarryIn;
      end
      `OP_ROR: carryNew = rotSrc[0];
      `OP_ROL: carryNew = rotSrc[7];
      default:
      begin
        carryNew = carryIn;
        nibbleNew = nibbleCarryIn;
      end
    endcase
  end

  // Data-path write; protected bits keep their old value
  always @*
  begin
    writeMerged = status_q;
    if (clearHit)
    begin
      writeMerged = mergeKeep(8'h00, status_q, `CS_CAUSE_MASK | `CS_FLAG_MASK);
    end
    else if (hitStatus && flagsUpdate)
    begin
      writeMerged = mergeKeep(writeData, status_q, `CS_FLAG_MASK | `CS_CAUSE_MASK);
    end
    else if (hitStatus)
    begin
      writeMerged = mergeKeep(writeData, status_q, `CS_CAUSE_MASK);
    end
  end

  // Hardware-only reset-cause bits; time-out and sleep take priority
  always @*
  begin
    expiryNext = status_q[`CS_WDX_BIT];
    sleepNext = status_q[`CS_SLP_BIT];
    if (watchdogTimeout)
    begin
      expiryNext = 1'b0;
    end
    else if (watchdogKick || sleepOp)
    begin
      expiryNext = 1'b1;
    end
    if (sleepOp)
    begin
      sleepNext = 1'b0;
    end
    else if (watchdogKick)
    begin
      sleepNext = 1'b1;
    end
  end

  // Next status: flag logic overrides the data write
  always @*
  begin
    status_d = writeMerged;
    if (clearHit)
    begin
      status_d[`CS_Z_BIT] = 1'b1;
    end
    else if (flagZero)
    begin
      status_d[`CS_Z_BIT] = zeroIn;
    end
    if (flagNibble)
      status_d[`CS_DC_BIT] = nibbleNew;
    if (flagCarry)
      status_d[`CS_C_BIT] = carryNew;
    status_d[`CS_WDX_BIT] = expiryNext;
    status_d[`CS_SLP_BIT] = sleepNext;
  end

  // Bank bits taken from the next status, so addresses track it
  always @*
  begin
    directBankNext = {status_d[`CS_RPHI_BIT], status_d[`CS_RPLO_BIT]};
    indirectBankNext = status_d[`CS_IRP_BIT];
  end

  // Stored status
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      status_q <= `CS_RESET;
    else
      status_q <= status_d;
  end

  // Registered outputs, same edge as the stored status
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      statusOut <= `CS_RESET;
      directFullAddr <= {ADDR_W{1'b0}};
      indirectFullAddr <= {ADDR_W{1'b0}};
    end
    else
    begin
      statusOut <= status_d;
      directFullAddr <= {directBankNext, directAddr};
      indirectFullAddr <= {indirectBankNext, indirectPtr};
    end
  end

endmodule // cpu_status_register
`default_nettype wire

// ### tb/core_alu_model.sv
`timescale 1ns/1ns
`default_nettype none
// Core side: zero flag of the result it writes back
module core_alu_model (
  input wire logic [7:0] result,
  output logic zero
);
  assign zero = result == 8'h00;
endmodule // core_alu_model
`default_nettype wire

// ### tb/cpu_status_props.sv
`timescale 1ns/1ns
`default_nettype none
module status_props (
  input wire clk,
  input wire sys_rst,
  input wire [6:0] fileAddr,
  input wire writeEn,
  input wire [7:0] writeData,
  input wire [2:0] opClass,
  input wire flagsUpdate,
  input wire carryIn,
  input wire [7:0] rotSrc,
  input wire watchdogKick,
  input wire sleepOp,
  input wire watchdogTimeout,
  input wire [7:0] statusOut
);
  // Status hit and quiet cause inputs
  wire hit = writeEn && fileAddr == 7'h03;
  wire quiet = !(watchdogKick || sleepOp || watchdogTimeout);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  cause_ro_a: assert property (hit && quiet |=> $stable(statusOut[4:3])) else $error("cause written");
  tmo_clr_a: assert property (watchdogTimeout |=> !statusOut[4]) else $error("expiry kept");
  kick_set_a: assert property (watchdogKick && !sleepOp && !watchdogTimeout |=> statusOut[4:3] == 2'h3) else $error("kick");
  sleep_set_a: assert property (sleepOp && !watchdogTimeout |=> statusOut[4:3] == 2'h2) else $error("sleep");
  clear_bank_a: assert property (hit && opClass == 3'h5 |=> statusOut[7:5] == 3'h0 && statusOut[2]) else $error("clear");
  plain_wr_a: assert property (hit && opClass == 3'h0 && !flagsUpdate |=> statusOut[7:5] == $past(writeData[7:5]))
    else $error("write");
  sub_borrow_a: assert property (flagsUpdate && opClass == 3'h2 |=> statusOut[0] != $past(carryIn)) else $error("borrow");
  rot_carry_a: assert property (flagsUpdate && opClass == 3'h3 |=> statusOut[0] == $past(rotSrc[0])) else $error("rot");
endmodule // status_props
bind cpu_status_register status_props propsChk (.clk, .sys_rst, .fileAddr, .writeEn, .writeData, .opClass,
  .flagsUpdate, .carryIn, .rotSrc, .watchdogKick, .sleepOp, .watchdogTimeout, .statusOut);
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'h0, sys_rst = 1'h1, we = 1'h0, fu = 1'h0, cy = 1'h0, dc = 1'h0, zero;
  logic [2:0] op = 3'h0, cause = 3'h0;
  logic [6:0] fa = 7'h03;
  logic [7:0] wd = 8'h00, rs = 8'h00, st;
  logic [8:0] dAddr, iAddr;
  int mismatches = 0, samples_checked = 0;
  // Rows: op, flag enable, carry, wrap, data, rotate source, status
  logic [29:0] rows [7] = '{{3'h0, 3'h0, 8'he7, 8'h00, 8'hff}, {3'h5, 3'h0, 8'h00, 8'h00, 8'h1f},
    {3'h1, 3'h4, 8'h27, 8'h00, 8'h38}, {3'h2, 3'h6, 8'h20, 8'h00, 8'h3a},
    {3'h3, 3'h4, 8'h80, 8'h01, 8'h9b}, {3'h4, 3'h4, 8'hfe, 8'h7f, 8'hfa},
    {3'h1, 3'h7, 8'h00, 8'h00, 8'h1f}};
  core_alu_model core (.result(wd), .zero(zero));
  cpu_status_register dut (.clk(clk), .sys_rst(sys_rst), .fileAddr(fa), .writeEn(we), .writeData(wd),
    .opClass(op), .flagsUpdate(fu), .zeroIn(zero), .carryIn(cy), .nibbleCarryIn(dc), .rotSrc(rs),
    .watchdogKick(cause[0]), .sleepOp(cause[1]), .watchdogTimeout(cause[2]), .directAddr(7'h7f),
    .indirectPtr(8'hff), .statusOut(st), .directFullAddr(dAddr), .indirectFullAddr(iAddr));
  task chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp)
      mismatches++;
    if (got !== exp)
      $display("CHECK FAILED %0t %h %h", $time, got, exp);
  endtask
  // One status write, then compare
  task step(input logic [29:0] r);
    @(posedge clk);
    {op, fu, cy, dc, wd, rs} <= r[29:8];
    we <= 1'h1;
    @(posedge clk);
    {we, fu} <= 2'h0;
    #1 chk({1'h0, st}, {1'h0, r[7:0]});
  endtask
  // One cause pulse, then compare
  task pulse(input logic [2:0] c, input logic [1:0] e);
    @(posedge clk);
    cause <= c;
    @(posedge clk);
    cause <= 3'h0;
    #1 chk({7'h00, st[4:3]}, {7'h00, e});
  endtask
  task test_done;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Clock and watchdog
  initial forever #2 clk = ~clk;
  initial
  begin
    #2000 mismatches++;
    test_done;
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    #1 chk({1'h0, st}, 9'h018);
    foreach (rows[i])
      step(rows[i]);
    for (int i = 0; i < 4; i++)
    begin
      step({6'h00, i[1], i[1:0], 13'h0000, i[1], i[1:0], 5'h18});
      chk(dAddr, {i[1:0], 7'h7f});
      chk(iAddr, {i[1], 8'hff});
    end
    pulse(3'h4, 2'h1);
    pulse(3'h2, 2'h2);
    pulse(3'h1, 2'h3);
    pulse(3'h5, 2'h1);
    fa <= 7'h04;
    step({3'h0, 3'h0, 8'h00, 8'h00, 8'he8});
    sys_rst <= 1'h1;
    @(posedge clk);
    sys_rst <= 1'h0;
    #1 chk({1'h0, st}, 9'h018);
    chk(dAddr, 9'h000);
    test_done;
  end
endmodule // tb_top
`default_nettype wire
